/* hw/rms_defs.vh */
// register map, field codes and constants of the reading store
`ifndef RMS_DEFS_VH
`define RMS_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RMS_MODE_OFS 8'h00
`define RMS_FMT_OFS 8'h04
`define RMS_RPT_OFS 8'h08
`define RMS_RC_FIRST_OFS 8'h0C
`define RMS_RC_COUNT_OFS 8'h10
`define RMS_RC_RECORD_OFS 8'h14
`define RMS_COUNT_OFS 8'h18
`define RMS_SIZE_OFS 8'h1C
`define RMS_CAP_OFS 8'h20
`define RMS_STAT_OFS 8'h24
`define RMS_OUT0_OFS 8'h28
`define RMS_OUT1_OFS 8'h2C
`define RMS_OUT2_OFS 8'h30
`define RMS_OUT3_OFS 8'h34
`define RMS_REQ_OFS 8'h38
`define RMS_SCALE_OFS 8'h3C

// ----------------------------------------------------------------
// memory-mode command codes
// ----------------------------------------------------------------
`define RMS_CMD_OFF 2'h0
`define RMS_CMD_FIFO 2'h1
`define RMS_CMD_LIFO 2'h2
`define RMS_CMD_RESUME_STORING 2'h3

// ----------------------------------------------------------------
// format codes and field positions of the format register
// ----------------------------------------------------------------
`define RMS_F_TEXT 3'h0
`define RMS_F_SHORT 3'h1
`define RMS_F_LONG 3'h2
`define RMS_F_SINGLE 3'h3
`define RMS_F_DOUBLE 3'h4
`define RMS_SFMT_LSB 0
`define RMS_OFMT_LSB 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RMS_SFMT_RST 3'h3
`define RMS_OFMT_RST 3'h0
`define RMS_RPT_RST 16'h0001
`define RMS_RC_COUNT_RST 16'h0001

// ----------------------------------------------------------------
// float layout and overload codes
// ----------------------------------------------------------------
`define RMS_DBL_BIAS 11'h3FF
`define RMS_SGL_BIAS 8'h7F
`define RMS_BIAS_DIFF 11'h380
`define RMS_OVL_DBL 63'h47D2CED32A16A1B1
`define RMS_OVL_SGL 31'h7E967699
`define RMS_OVL_TEXT 112'h312E3030303030303030452B3338
`define RMS_PLUS 8'h2B
`define RMS_MINUS 8'h2D
`define RMS_OVL_SHORT_P 16'h7FFF
`define RMS_OVL_SHORT_N 16'h8000
`define RMS_OVL_LONG_P 32'h7FFFFFFF
`define RMS_OVL_LONG_N 32'h80000000

`endif

/* hw/rms_store.v */
// reading memory store with APB register access and format conversion
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "rms_defs.vh"

module rms_store #(
	parameter STORE_BYTES = 1024,
	parameter AW = 9
)(
	input wire clk_sys,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	input wire rd_valid,
	input wire rd_ovld,
	input wire [119:0] rd_text,
	input wire [31:0] rd_int,
	input wire [63:0] rd_float,
	input wire [15:0] scale_cfg,
	output reg out_valid,
	output reg [127:0] out_data
);
	localparam DEPTH = 1 << AW;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg [127:0] mem [0:DEPTH-1];
	reg [1:0] flag_mem [0:DEPTH-1];
	reg store_en;
	reg [1:0] mode;
	reg [2:0] sfmt;
	reg [2:0] ofmt;
	reg [15:0] rpt;
	reg [15:0] rc_first;
	reg [15:0] rc_count;
	reg [15:0] rc_record;
	reg [AW-1:0] wp;
	reg [AW:0] cnt;
	reg busy;
	reg [31:0] rc_num;
	reg [15:0] rc_left;
	reg out_ovl;
	reg out_mismatch;
	reg rc_err;
	reg [15:0] out_scale;

	reg [AW-1:0] next_wp;
	reg [AW:0] next_cnt;
	reg next_en;
	reg [1:0] next_mode;
	reg [2:0] next_sfmt;
	reg wr_en;
	reg rd_en;
	reg rd_fail;
	reg [AW-1:0] rd_idx;
	reg [31:0] next_num;

	wire acc = psel & penable;
	wire wr_acc = acc & pwrite;
	wire mode_wr = wr_acc & (paddr == `RMS_MODE_OFS);
	wire fmt_wr = wr_acc & (paddr == `RMS_FMT_OFS);
	wire rec_wr = wr_acc & (paddr == `RMS_RC_RECORD_OFS);
	wire req_wr = wr_acc & (paddr == `RMS_REQ_OFS);

	assign pready = 1'b1;

	// ------------------------------------------------------------
	// capacity per storage format
	// ------------------------------------------------------------
	reg [2:0] shift;
	always @*
	begin
		case (sfmt)
			`RMS_F_TEXT: shift = 3'd4;
			`RMS_F_SHORT: shift = 3'd1;
			`RMS_F_DOUBLE: shift = 3'd3;
			default: shift = 3'd2;
		endcase
	end
	wire [31:0] size_bytes = STORE_BYTES;
	wire [31:0] cap32 = size_bytes >> shift;
	wire [AW:0] cap = cap32[AW:0];
	wire [AW-1:0] mask = cap32[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};

	// ------------------------------------------------------------
	// conversion helpers
	// ------------------------------------------------------------
	function [31:0] to_single;
		input [63:0] d;
		reg [10:0] e;
		begin
			e = d[62:52] - `RMS_BIAS_DIFF;
			if (d[62:52] <= `RMS_BIAS_DIFF)
				to_single = {d[63], 31'h0};
			else if (e >= 11'h0FF)
				to_single = {d[63], 8'hFF, 23'h0};
			else
				to_single = {d[63], e[7:0], d[51:29]};
		end
	endfunction

	function [63:0] to_double;
		input [31:0] s;
		begin
			if (s[30:23] == 8'h00)
				to_double = {s[31], 63'h0};
			else
				to_double = {s[31], {3'h0, s[30:23]} + `RMS_BIAS_DIFF, s[22:0], 29'h0};
		end
	endfunction

	// stored value for an incoming reading
	reg [127:0] wr_data;
	wire ovl_neg = rd_float[63];
	always @*
	begin
		wr_data = 128'h0;
		case (sfmt)
			`RMS_F_TEXT:
				if (rd_ovld)
					wr_data = {ovl_neg ? `RMS_MINUS : `RMS_PLUS, `RMS_OVL_TEXT, 8'h00};
				else
					wr_data = {rd_text, 8'h00};
			`RMS_F_SHORT:
				if (rd_ovld)
					wr_data[15:0] = ovl_neg ? `RMS_OVL_SHORT_N : `RMS_OVL_SHORT_P;
				else
					wr_data[15:0] = rd_int[15:0];
			`RMS_F_LONG:
				if (rd_ovld)
					wr_data[31:0] = ovl_neg ? `RMS_OVL_LONG_N : `RMS_OVL_LONG_P;
				else
					wr_data[31:0] = rd_int;
			`RMS_F_DOUBLE:
				if (rd_ovld)
					wr_data[63:0] = {ovl_neg, `RMS_OVL_DBL};
				else
					wr_data[63:0] = rd_float;
			default:
				if (rd_ovld)
					wr_data[31:0] = {ovl_neg, `RMS_OVL_SGL};
				else
					wr_data[31:0] = to_single(rd_float);
		endcase
	end

	// ------------------------------------------------------------
	// pointer and mode next state
	// ------------------------------------------------------------
	wire [31:0] rc_start = {16'h0, rc_first} + ((pwdata[15:0] == 16'h0) ? 32'h0 :
		({16'h0, pwdata[15:0]} - 32'h1) * {16'h0, rpt});
	wire [31:0] cnt32 = {{(31-AW){1'b0}}, cnt};
	wire rc_take = busy & ~out_valid;
	wire pop_req = req_wr & ~out_valid & ~busy;

	always @*
	begin
		next_wp = wp;
		next_cnt = cnt;
		next_en = store_en;
		next_mode = mode;
		next_sfmt = sfmt;
		wr_en = 1'b0;
		rd_en = 1'b0;
		rd_fail = 1'b0;
		rd_idx = wp;
		next_num = rc_num;
		if (mode_wr)
		begin
			case (pwdata[1:0])
				`RMS_CMD_OFF: next_en = 1'b0;
				`RMS_CMD_RESUME_STORING: next_en = 1'b1;
				default:
				begin
					next_en = 1'b1;
					next_mode = pwdata[1:0];
					next_wp = {AW{1'b0}};
					next_cnt = {(AW+1){1'b0}};
				end
			endcase
		end
		else if (fmt_wr && pwdata[`RMS_SFMT_LSB+2:`RMS_SFMT_LSB] != sfmt
			&& pwdata[`RMS_SFMT_LSB+2:`RMS_SFMT_LSB] <= `RMS_F_DOUBLE)
		begin
			// storage format changes, so held readings are dropped
			next_sfmt = pwdata[`RMS_SFMT_LSB+2:`RMS_SFMT_LSB];
			next_wp = {AW{1'b0}};
			next_cnt = {(AW+1){1'b0}};
		end
		else
		begin
			if (rec_wr)
				next_en = 1'b0;
			if (rd_valid && store_en)
			begin
				if (mode == `RMS_CMD_LIFO)
				begin
					wr_en = 1'b1;
					next_wp = (wp + {{(AW-1){1'b0}}, 1'b1}) & mask;
					if (cnt < cap)
						next_cnt = cnt + {{AW{1'b0}}, 1'b1};
				end
				else if (cnt < cap)
				begin
					wr_en = 1'b1;
					next_wp = (wp + {{(AW-1){1'b0}}, 1'b1}) & mask;
					next_cnt = cnt + {{AW{1'b0}}, 1'b1};
				end
			end
			if (rc_take)
			begin
				// reading n sits n places behind the write pointer
				if (rc_num == 32'h0 || rc_num > cnt32)
					rd_fail = 1'b1;
				else
				begin
					rd_en = 1'b1;
					rd_idx = (wp - rc_num[AW-1:0]) & mask;
				end
				next_num = rc_num + 32'h1;
			end
			else if (pop_req && store_en && next_cnt != {(AW+1){1'b0}})
			begin
				rd_en = 1'b1;
				if (mode == `RMS_CMD_LIFO)
				begin
					rd_idx = (next_wp - {{(AW-1){1'b0}}, 1'b1}) & mask;
					next_wp = rd_idx;
				end
				else
					rd_idx = (next_wp - next_cnt[AW-1:0]) & mask;
				next_cnt = next_cnt - {{AW{1'b0}}, 1'b1};
			end
			// start number from the record value being written
			if (rec_wr)
				next_num = rc_start;
		end
	end

	// ------------------------------------------------------------
	// store array
	// ------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (wr_en)
		begin
			mem[wp] <= wr_data;
			flag_mem[wp] <= {rd_ovld, ovl_neg};
		end
	end

	// lifo store and pop in one cycle hit the same slot
	wire bypass = wr_en & (rd_idx == wp);
	wire [127:0] rd_word = bypass ? wr_data : mem[rd_idx];
	wire [1:0] rd_flag = bypass ? {rd_ovld, ovl_neg} : flag_mem[rd_idx];

	// ------------------------------------------------------------
	// output format conversion
	// ------------------------------------------------------------
	reg [127:0] cv_data;
	reg cv_mis;
	always @*
	begin
		cv_data = 128'h0;
		cv_mis = 1'b0;
		case (ofmt)
			`RMS_F_TEXT:
				if (rd_flag[1])
					cv_data = {rd_flag[0] ? `RMS_MINUS : `RMS_PLUS, `RMS_OVL_TEXT, 8'h00};
				else
				begin
					cv_data = rd_word;
					cv_mis = (sfmt != `RMS_F_TEXT);
				end
			`RMS_F_SHORT:
				if (rd_flag[1])
					cv_data[15:0] = rd_flag[0] ? `RMS_OVL_SHORT_N : `RMS_OVL_SHORT_P;
				else
				begin
					cv_data[15:0] = rd_word[15:0];
					cv_mis = (sfmt != `RMS_F_SHORT) && (sfmt != `RMS_F_LONG);
				end
			`RMS_F_LONG:
				if (rd_flag[1])
					cv_data[31:0] = rd_flag[0] ? `RMS_OVL_LONG_N : `RMS_OVL_LONG_P;
				else if (sfmt == `RMS_F_SHORT)
					cv_data[31:0] = {{16{rd_word[15]}}, rd_word[15:0]};
				else
				begin
					cv_data[31:0] = rd_word[31:0];
					cv_mis = (sfmt != `RMS_F_LONG);
				end
			`RMS_F_DOUBLE:
				if (rd_flag[1])
					cv_data[63:0] = {rd_flag[0], `RMS_OVL_DBL};
				else if (sfmt == `RMS_F_SINGLE)
					cv_data[63:0] = to_double(rd_word[31:0]);
				else
				begin
					cv_data[63:0] = rd_word[63:0];
					cv_mis = (sfmt != `RMS_F_DOUBLE);
				end
			default:
				if (rd_flag[1])
					cv_data[31:0] = {rd_flag[0], `RMS_OVL_SGL};
				else if (sfmt == `RMS_F_DOUBLE)
					cv_data[31:0] = to_single(rd_word[63:0]);
				else
				begin
					cv_data[31:0] = rd_word[31:0];
					cv_mis = (sfmt != `RMS_F_SINGLE);
				end
		endcase
	end

	// ------------------------------------------------------------
	// control registers and output buffer
	// ------------------------------------------------------------
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			store_en <= 1'b0;
			mode <= `RMS_CMD_FIFO;
			sfmt <= `RMS_SFMT_RST;
			ofmt <= `RMS_OFMT_RST;
			rpt <= `RMS_RPT_RST;
			rc_first <= 16'h0001;
			rc_count <= `RMS_RC_COUNT_RST;
			rc_record <= 16'h0;
			wp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
			busy <= 1'b0;
			rc_num <= 32'h0;
			rc_left <= 16'h0;
			out_valid <= 1'b0;
			out_data <= 128'h0;
			out_ovl <= 1'b0;
			out_mismatch <= 1'b0;
			rc_err <= 1'b0;
			out_scale <= 16'h0;
		end
		else
		begin
			store_en <= next_en;
			mode <= next_mode;
			sfmt <= next_sfmt;
			wp <= next_wp;
			cnt <= next_cnt;
			rc_num <= next_num;
			if (fmt_wr && pwdata[`RMS_OFMT_LSB+2:`RMS_OFMT_LSB] <= `RMS_F_DOUBLE)
				ofmt <= pwdata[`RMS_OFMT_LSB+2:`RMS_OFMT_LSB];
			if (wr_acc && paddr == `RMS_RPT_OFS)
				rpt <= pwdata[15:0];
			if (wr_acc && paddr == `RMS_RC_FIRST_OFS)
				rc_first <= pwdata[15:0];
			if (wr_acc && paddr == `RMS_RC_COUNT_OFS)
				rc_count <= pwdata[15:0];
			if (rec_wr)
				rc_record <= pwdata[15:0];
			if (req_wr && out_valid)
				out_valid <= 1'b0;
			else if (rd_en)
			begin
				out_valid <= 1'b1;
				out_data <= cv_data;
				out_ovl <= rd_flag[1];
				out_mismatch <= cv_mis;
				out_scale <= scale_cfg;
			end
			if (rc_take)
			begin
				rc_left <= rc_left - 16'h1;
				if (rd_fail || rc_left == 16'h1)
					busy <= 1'b0;
				if (rd_fail)
					rc_err <= 1'b1;
			end
			if (rec_wr)
			begin
				// record written last so it starts the recall
				busy <= (rc_count != 16'h0);
				rc_left <= rc_count;
				rc_err <= 1'b0;
				out_valid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// apb read data
	// ------------------------------------------------------------
	reg [31:0] rdata;
	reg hit;
	always @*
	begin
		rdata = 32'h0;
		hit = 1'b1;
		case (paddr)
			`RMS_MODE_OFS: rdata = {29'h0, store_en, mode};
			`RMS_FMT_OFS: rdata = {25'h0, ofmt, 1'b0, sfmt};
			`RMS_RPT_OFS: rdata = {16'h0, rpt};
			`RMS_RC_FIRST_OFS: rdata = {16'h0, rc_first};
			`RMS_RC_COUNT_OFS: rdata = {16'h0, rc_count};
			`RMS_RC_RECORD_OFS: rdata = {16'h0, rc_record};
			`RMS_COUNT_OFS: rdata = cnt32;
			`RMS_SIZE_OFS: rdata = size_bytes;
			`RMS_CAP_OFS: rdata = cap32;
			`RMS_STAT_OFS: rdata = {27'h0, rc_err, out_mismatch, busy, out_ovl, out_valid};
			`RMS_OUT0_OFS: rdata = out_data[31:0];
			`RMS_OUT1_OFS: rdata = out_data[63:32];
			`RMS_OUT2_OFS: rdata = out_data[95:64];
			`RMS_OUT3_OFS: rdata = out_data[127:96];
			`RMS_REQ_OFS: rdata = 32'h0;
			`RMS_SCALE_OFS: rdata = {16'h0, out_scale};
			default: hit = 1'b0;
		endcase
	end

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end
		else if (psel & ~penable)
		begin
			prdata <= pwrite ? 32'h0 : rdata;
			pslverr <= ~hit;
		end
		else if (acc)
			pslverr <= 1'b0;
	end

endmodule // rms_store

/* hw/rms_fix.v */
// no logic here: the store module holds all of it
`timescale 1ns/1ps

/* testbench/rms_store_sva.sv */
// port assertions for the reading store
`timescale 1ns/1ps
module rms_store_sva #(
	parameter STORE_BYTES = 1024
)(
	input wire clk_sys,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire rd_valid,
	input wire rd_ovld,
	input wire [119:0] rd_text,
	input wire [31:0] rd_int,
	input wire [63:0] rd_float,
	input wire [15:0] scale_cfg,
	input wire out_valid,
	input wire [127:0] out_data
);
	wire acc = psel && penable;
	wire rd_acc = acc && !pwrite;
	wire wr_req = acc && pwrite && paddr == 8'h38;
	wire wr_rec = acc && pwrite && paddr == 8'h14;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	ready_tied_a: assert property (pready)
		else $error("pready low");
	map_error_a: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h3C))
		else $error("pslverr wrong for address");
	unmapped_zero_a: assert property (rd_acc && paddr > 8'h3C |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	size_read_a: assert property (rd_acc && paddr == 8'h1C |-> prdata == STORE_BYTES)
		else $error("size read wrong");
	status_valid_a: assert property (rd_acc && paddr == 8'h24 |-> prdata[0] == $past(out_valid))
		else $error("status valid bit wrong");
	count_bound_a: assert property (rd_acc && paddr == 8'h18 |-> prdata <= STORE_BYTES / 2)
		else $error("count above capacity");
	buffer_hold_a: assert property (out_valid && !(acc && pwrite) |=> out_valid && $stable(out_data))
		else $error("output buffer changed untouched");
	consume_a: assert property (wr_req && out_valid |=> !out_valid)
		else $error("request did not consume");
	rise_cause_a: assert property ($rose(out_valid) |-> $past(wr_req) || $past(wr_rec, 2) || $past(wr_req, 2))
		else $error("output loaded without request");
	cover property (wr_req && out_valid);
	cover property (wr_rec);
	cover property (acc && pslverr);
endmodule // rms_store_sva

bind rms_store rms_store_sva #(.STORE_BYTES(STORE_BYTES)) i_sva (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.rd_valid(rd_valid), .rd_ovld(rd_ovld), .rd_text(rd_text), .rd_int(rd_int),
	.rd_float(rd_float), .scale_cfg(scale_cfg), .out_valid(out_valid), .out_data(out_data));

/* testbench/rms_source.sv */
// reading source model feeding the store
`timescale 1ns/1ps
module rms_source (
	input wire clk_sys,
	output logic rd_valid,
	output logic rd_ovld,
	output logic [119:0] rd_text,
	output logic [31:0] rd_int,
	output logic [63:0] rd_float
);
	initial
	begin
		rd_valid = 1'b0;
		rd_ovld = 1'b0;
		rd_text = 120'h0;
		rd_int = 32'h0;
		rd_float = 64'h0;
	end
	// one reading, then data lines scrambled
	task automatic send(input logic [3:0] n, input logic ovl);
		@(posedge clk_sys);
		rd_valid <= 1'b1;
		rd_ovld <= ovl;
		rd_text <= {15{4'h3, n}};
		rd_int <= {28'h0, n};
		rd_float <= ovl ? 64'hC000000000000000 : 64'h4000000000000000 | {16'h0, n, 44'h0};
		@(posedge clk_sys);
		rd_valid <= 1'b0;
		rd_ovld <= ~rd_ovld;
		rd_text <= ~rd_text;
		rd_int <= ~rd_int;
		rd_float <= ~rd_float;
	endtask
endmodule // rms_source

/* testbench/reading_memory_store_bench.sv */
// self-checking bench for the reading store
`timescale 1ns/1ps
`include "rms_defs.vh"
module reading_memory_store_bench;
	logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, out_valid, e;
	logic rd_valid, rd_ovld;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, lo, rd_int;
	logic [15:0] scale_cfg;
	logic [119:0] rd_text;
	logic [63:0] rd_float;
	logic [127:0] out_data;
	int err_total = 0;
	int comparisons = 0;
	logic [15:0] rows [5] = '{16'h0004, 16'h0120, 16'h0210, 16'h0310, 16'h0408};

	rms_store #(.STORE_BYTES(64), .AW(5)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .rd_valid(rd_valid),
		.rd_ovld(rd_ovld), .rd_text(rd_text), .rd_int(rd_int), .rd_float(rd_float),
		.scale_cfg(scale_cfg), .out_valid(out_valid), .out_data(out_data));
	rms_source i_src (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_ovld(rd_ovld),
		.rd_text(rd_text), .rd_int(rd_int), .rd_float(rd_float));

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ----
	// helpers
	// ----
	function automatic logic [63:0] fv(input logic [3:0] n);
		return 64'h4000000000000000 | {16'h0, n, 44'h0};
	endfunction
	task automatic chk(input logic [127:0] s, input logic [127:0] x);
		comparisons++;
		if (s !== x)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
			@(posedge clk_sys);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	// wait for a loaded reading, read it out, consume it
	task automatic take(input logic [63:0] x);
		while (out_valid !== 1'b1)
			@(posedge clk_sys);
		apb(1'b0, `RMS_OUT0_OFS, 32'h0);
		lo = q;
		apb(1'b0, `RMS_OUT1_OFS, 32'h0);
		chk({q, lo}, x);
		wr(`RMS_REQ_OFS, 32'h0);
	endtask
	task automatic pop(input logic [63:0] x);
		wr(`RMS_REQ_OFS, 32'h0);
		take(x);
	endtask
	task automatic note(input string s);
		$display("test %s finished", s);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		$display("mismatch at %0t: watchdog expired", $time);
		complete_run();
	end

	initial
	begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		scale_cfg = 16'h0005;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdc(`RMS_FMT_OFS, 32'h3);
		rdc(`RMS_COUNT_OFS, 32'h0);
		rdc(`RMS_SIZE_OFS, 32'h40);
		apb(1'b0, 8'hC0, 32'h0);
		chk(e, 1'b1);
		note("reset");
		for (int i = 0; i < 5; i++)
		begin
			wr(`RMS_FMT_OFS, {24'h0, rows[i][15:8]});
			rdc(`RMS_CAP_OFS, {24'h0, rows[i][7:0]});
		end
		note("capacity");
		wr(`RMS_FMT_OFS, 32'h43);
		wr(`RMS_MODE_OFS, 32'h1);
		for (int k = 1; k < 4; k++)
			i_src.send(4'(k), 1'b0);
		rdc(`RMS_COUNT_OFS, 32'h3);
		scale_cfg <= 16'h00A5;
		pop(fv(1));
		rdc(`RMS_SCALE_OFS, 32'hA5);
		wr(`RMS_MODE_OFS, 32'h0);
		i_src.send(4'h4, 1'b0);
		rdc(`RMS_COUNT_OFS, 32'h2);
		wr(`RMS_MODE_OFS, 32'h3);
		i_src.send(4'h5, 1'b0);
		rdc(`RMS_COUNT_OFS, 32'h3);
		pop(fv(2));
		note("fifo");
		wr(`RMS_RC_FIRST_OFS, 32'h2);
		wr(`RMS_RC_COUNT_OFS, 32'h1);
		wr(`RMS_RC_RECORD_OFS, 32'h1);
		take(fv(3));
		rdc(`RMS_COUNT_OFS, 32'h2);
		rdc(`RMS_MODE_OFS, 32'h1);
		wr(`RMS_MODE_OFS, 32'h2);
		rdc(`RMS_COUNT_OFS, 32'h0);
		note("recall");
		wr(`RMS_FMT_OFS, 32'h44);
		wr(`RMS_MODE_OFS, 32'h2);
		for (int k = 1; k < 10; k++)
			i_src.send(4'(k), 1'b0);
		rdc(`RMS_COUNT_OFS, 32'h8);
		wr(`RMS_RPT_OFS, 32'h2);
		wr(`RMS_RC_FIRST_OFS, 32'h1);
		wr(`RMS_RC_RECORD_OFS, 32'h2);
		take(fv(7));
		wr(`RMS_MODE_OFS, 32'h3);
		for (int k = 9; k > 1; k--)
			pop(fv(4'(k)));
		rdc(`RMS_COUNT_OFS, 32'h0);
		note("lifo");
		wr(`RMS_MODE_OFS, 32'h1);
		for (int k = 1; k < 10; k++)
			i_src.send(4'(k), 1'b0);
		rdc(`RMS_COUNT_OFS, 32'h8);
		pop(fv(1));
		wr(`RMS_MODE_OFS, 32'h1);
		i_src.send(4'h0, 1'b1);
		pop(64'h8000000000000000 | `RMS_OVL_DBL);
		note("overload");
		complete_run();
	end
endmodule // reading_memory_store_bench
